/* logic/hws_pkg.sv */
package hws_pkg;

  // bus geometry
  localparam int unsigned ADDR_W          = 8;          // byte address width on apb
  localparam int unsigned DATA_W          = 32;         // apb data width
  localparam int unsigned IDX_W           = 6;          // register index width (byte addr / 4)

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL_IDX        = 6'h0c; // control, holds the start bit
  localparam logic [IDX_W-1:0] SLOT_FIRST_IDX  = 6'h0f; // sequence_slot_first
  localparam logic [IDX_W-1:0] SLOT_SECOND_IDX = 6'h10; // sequence_slot_second
  localparam logic [IDX_W-1:0] STATUS_IDX      = 6'h18; // sequencer status, read only

  // field positions
  localparam int unsigned GO_BIT          = 0;          // start bit in control
  localparam int unsigned SLOT_FLAG_BIT   = 7;          // slot is a delay when set
  localparam int unsigned STAT_IDX_LSB    = 0;          // status: current slot number
  localparam int unsigned STAT_STATE_LSB  = 4;          // status: sequencer state code

  // reset values
  localparam logic [7:0] SLOT_FIRST_RST   = 8'h01;      // first slot plays effect 1
  localparam logic [7:0] SLOT_OTHER_RST   = 8'h00;      // other slots stop the sequence

  // timing
  localparam int unsigned SLOT_COUNT      = 8;          // slots walked before stopping
  localparam int unsigned CLK_PERIOD_NS   = 20;         // pclk at 50 mhz
  localparam int unsigned WAIT_UNIT_MS    = 10;         // one count of a delay slot
  localparam int unsigned WAIT_UNIT_CYC   = (WAIT_UNIT_MS * 1000000) / CLK_PERIOD_NS;

  // sequencer states, gray along idle -> fetch -> play
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_PLAY  = 2'b11,
    ST_WAIT  = 2'b10
  } hws_state_e;

endpackage : hws_pkg

/* logic/hws_delay_timer.sv */
`timescale 1ns/1ns
// counts a delay slot out in whole units of UNIT_CYCLES clocks
module hws_delay_timer #(
  parameter int unsigned UNIT_CYCLES = hws_pkg::WAIT_UNIT_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,    // load units and begin counting
  input  wire logic [6:0] units,    // delay length in units
  input  wire logic       abort,    // drop a running delay
  output logic            done      // one-cycle pulse at expiry
);
  import hws_pkg::*;

  logic        active_r;            // a delay is running
  logic [6:0]  units_r;             // units still to run
  logic [31:0] pre_r;               // clocks inside the current unit

  // unit prescaler and unit countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b0;
      units_r  <= 7'h00;
      pre_r    <= 32'h0;
    end else if (abort) begin
      active_r <= 1'b0;                         // cancelled, no pulse
      pre_r    <= 32'h0;
    end else if (start) begin
      active_r <= 1'b1;
      units_r  <= units;
      pre_r    <= 32'h0;
    end else if (active_r) begin
      if (units_r == 7'h00) begin
        active_r <= 1'b0;                       // expiry
      end else if (pre_r == 32'(UNIT_CYCLES - 1)) begin
        pre_r   <= 32'h0;
        units_r <= units_r - 7'h01;             // one 10 ms unit gone
      end else begin
        pre_r <= pre_r + 32'h1;
      end
    end
  end

  // expiry pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else begin
      done <= active_r && !abort && !start && (units_r == 7'h00);
    end
  end

  // helper: clocks since start, and the length loaded
  logic [31:0] elapsed_r;
  logic [6:0]  loaded_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_r <= 32'h0;
      loaded_r  <= 7'h00;
    end else if (start) begin
      elapsed_r <= 32'h0;
      loaded_r  <= units;
    end else if (active_r) begin
      elapsed_r <= elapsed_r + 32'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_delay_length: assert property (
    done |-> elapsed_r == 32'(loaded_r) * 32'(UNIT_CYCLES) + 32'h1)
    else $error("delay pulse not at units times unit length");

endmodule : hws_delay_timer

/* logic/hws_sequencer.sv */
`timescale 1ns/1ns
// What this block does
// - flag set: slot is an idle delay
// - delay lasts ten ms per count
// - flag clear: slot is effect index
// - start bit begins at first slot
// - after effect, advance to nonzero next slot
// - stop at zero id or eight slots
// - start bit stays high while playing
// - clearing start bit cancels playback at once
module hws_sequencer #(
  parameter int unsigned SLOT_COUNT  = hws_pkg::SLOT_COUNT,
  parameter int unsigned UNIT_CYCLES = hws_pkg::WAIT_UNIT_CYC
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [hws_pkg::ADDR_W-1:0] paddr,
  input  wire logic [hws_pkg::DATA_W-1:0] pwdata,
  output logic      [hws_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       effect_done,
  output logic                            effect_start,
  output logic      [6:0]                 effect_index,
  output logic                            effect_abort,
  output logic                            seq_busy
);
  import hws_pkg::*;

  localparam int unsigned SW = (SLOT_COUNT > 1) ? $clog2(SLOT_COUNT) : 1;
  localparam logic [SW-1:0] LAST_SLOT = SW'(SLOT_COUNT - 1);

  logic [7:0]       slot_r [SLOT_COUNT];  // sequence slots
  logic             go_r;                 // start bit
  hws_state_e       state_r;              // sequencer state
  hws_state_e       state_nxt;
  logic [SW-1:0]    idx_r;                // slot being played
  logic [SW-1:0]    idx_nxt;
  logic             go_nxt;

  // apb decode
  logic [IDX_W-1:0] reg_idx;              // word index of the access
  logic             acc;                  // access phase, answer ready
  logic             wr_en;                // write takes effect now
  logic             slot_hit;             // address inside the slot bank
  logic [SW-1:0]    slot_sel;             // slot addressed by the bus
  logic [IDX_W-1:0] slot_off;
  assign reg_idx  = paddr[ADDR_W-1:2];
  assign acc      = psel && penable && pready;
  assign wr_en    = acc && pwrite;
  assign slot_off = reg_idx - SLOT_FIRST_IDX;
  assign slot_hit = (reg_idx >= SLOT_FIRST_IDX) && (slot_off < IDX_W'(SLOT_COUNT));
  assign slot_sel = slot_off[SW-1:0];

  // software start-bit writes
  logic sw_go_wr;
  logic sw_go1;
  logic sw_go0;
  assign sw_go_wr = wr_en && (reg_idx == CTRL_IDX);
  assign sw_go1   = sw_go_wr && pwdata[GO_BIT];
  assign sw_go0   = sw_go_wr && !pwdata[GO_BIT];

  // current slot fields
  logic [7:0] slot_cur;
  logic       cur_delay;                  // top flag bit
  logic [6:0] cur_value;                  // effect index or delay count
  assign slot_cur  = slot_r[idx_r];
  assign cur_delay = slot_cur[SLOT_FLAG_BIT];
  assign cur_value = slot_cur[6:0];

  // step completion and stop conditions
  logic tmr_done;
  logic step_done;
  logic finish;
  logic advance;
  assign step_done = ((state_r == ST_PLAY) && effect_done)
                  || ((state_r == ST_WAIT) && tmr_done);
  assign finish    = ((state_r == ST_FETCH) && !cur_delay && (cur_value == 7'h00))
                  || (step_done && (idx_r == LAST_SLOT));
  assign advance   = step_done && (idx_r != LAST_SLOT);

  // delay timer for wait slots
  hws_delay_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .start   ((state_r == ST_FETCH) && cur_delay && !sw_go0),
    .units   (cur_value),
    .abort   (sw_go0),
    .done    (tmr_done)
  );

  // next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    if (sw_go0) begin
      state_nxt = ST_IDLE;                      // cancel at once
    end else if (sw_go1 && ((state_r == ST_IDLE) || finish)) begin
      state_nxt = ST_FETCH;                     // begin at first slot
      idx_nxt   = '0;
    end else begin
      case (state_r)
        ST_FETCH: begin
          if (cur_delay) begin
            state_nxt = ST_WAIT;                // idle instead of effect
          end else if (cur_value == 7'h00) begin
            state_nxt = ST_IDLE;                // zero id stops
          end else begin
            state_nxt = ST_PLAY;                // play library index
          end
        end
        ST_PLAY, ST_WAIT: begin
          if (advance) begin
            state_nxt = ST_FETCH;               // next slot
            idx_nxt   = idx_r + SW'(1);
          end else if (finish) begin
            state_nxt = ST_IDLE;                // eighth slot done
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // start bit: software write wins over completion
  always_comb begin
    go_nxt = go_r;
    if (sw_go0) begin
      go_nxt = 1'b0;
    end else if (sw_go1) begin
      go_nxt = 1'b1;
    end else if (finish) begin
      go_nxt = 1'b0;                            // cleared at completion
    end
  end

  // sequencer state and slot pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      idx_r   <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
    end
  end

  // start bit and busy flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_r     <= 1'b0;
      seq_busy <= 1'b0;
    end else begin
      go_r     <= go_nxt;
      seq_busy <= go_nxt;
    end
  end

  // effect requests towards the playback engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      effect_start <= 1'b0;
      effect_index <= 7'h00;
      effect_abort <= 1'b0;
    end else begin
      effect_start <= (state_r == ST_FETCH) && !cur_delay
                   && (cur_value != 7'h00) && !sw_go0;
      effect_abort <= sw_go0 && (state_r != ST_IDLE);
      if ((state_r == ST_FETCH) && !cur_delay) begin
        effect_index <= cur_value;
      end
    end
  end

  // slot registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        slot_r[i] <= (i == 0) ? SLOT_FIRST_RST : SLOT_OTHER_RST;
      end
    end else if (wr_en && slot_hit) begin
      slot_r[slot_sel] <= pwdata[7:0];
    end
  end

  // read data and error for the access phase
  logic [DATA_W-1:0] rdata_nxt;
  logic              err_nxt;
  always_comb begin
    rdata_nxt = '0;
    err_nxt   = 1'b0;
    if (reg_idx == CTRL_IDX) begin
      rdata_nxt[GO_BIT] = go_r;
    end else if (slot_hit) begin
      rdata_nxt[7:0] = slot_r[slot_sel];
    end else if (reg_idx == STATUS_IDX) begin
      rdata_nxt[STAT_IDX_LSB +: SW]   = idx_r;
      rdata_nxt[STAT_STATE_LSB +: 2]  = state_r;
    end else begin
      err_nxt = 1'b1;                           // unmapped address
    end
  end

  // apb answer: one wait state, then ready with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? '0 : rdata_nxt;
      pslverr <= err_nxt;
    end else begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_holds_go: assert property (
    (state_r != ST_IDLE) |-> go_r && seq_busy)
    else $error("start bit low while sequencer runs");

  a_start_first_slot: assert property (
    (sw_go1 && state_r == ST_IDLE) |=> state_r == ST_FETCH && idx_r == '0 ##1
    (state_r != ST_IDLE || !go_r || $past(sw_go1) || $past(sw_go0)))
    else $error("start did not fetch the first slot");

  a_delay_no_effect: assert property (
    (state_r == ST_FETCH && cur_delay && !sw_go0) |=> state_r == ST_WAIT
    ##1 !effect_start)
    else $error("delay slot drove an effect");

  a_effect_index: assert property (
    (state_r == ST_FETCH && !cur_delay && cur_value != 7'h00 && !sw_go0)
    |=> effect_start && effect_index == $past(cur_value) && state_r == ST_PLAY)
    else $error("effect slot did not request its index");

  a_advance_next: assert property (
    (state_r == ST_PLAY && effect_done && idx_r != LAST_SLOT && !sw_go_wr)
    |=> state_r == ST_FETCH && idx_r == $past(idx_r) + SW'(1))
    else $error("sequencer did not advance after effect");

  a_delay_advance: assert property (
    (state_r == ST_WAIT && tmr_done && idx_r != LAST_SLOT && !sw_go_wr)
    |=> state_r == ST_FETCH && idx_r == $past(idx_r) + SW'(1))
    else $error("sequencer did not advance after delay");

  a_zero_stops: assert property (
    (state_r == ST_FETCH && !cur_delay && cur_value == 7'h00 && !sw_go_wr)
    |=> state_r == ST_IDLE && !go_r && !effect_start)
    else $error("zero identifier did not stop the sequence");

  a_last_slot_stops: assert property (
    (step_done && idx_r == LAST_SLOT && !sw_go_wr) |=> state_r == ST_IDLE && !go_r)
    else $error("sequence ran past the last slot");

  a_cancel_now: assert property (
    (sw_go0 && state_r != ST_IDLE) |=> state_r == ST_IDLE && effect_abort && !go_r
    ##1 !effect_start)
    else $error("clearing start bit did not cancel");

  c_delay_slot:   cover property (state_r == ST_WAIT ##1 tmr_done);
  c_zero_stop:    cover property (state_r == ST_FETCH && cur_value == 7'h00 && !cur_delay);
  c_all_slots:    cover property (step_done && idx_r == LAST_SLOT);
  c_cancel:       cover property (sw_go0 && state_r == ST_PLAY);

endmodule : hws_sequencer

/* dv/tb.sv */
`timescale 1ns/1ns
module tb;
  import hws_pkg::*;

  localparam int unsigned UNIT = 4;     // shortened delay unit in clocks

  logic        pclk;                    // bus clock
  logic        presetn;                 // async reset, active low
  logic        psel;                    // apb select
  logic        penable;                 // apb enable
  logic        pwrite;                  // apb direction
  logic [7:0]  paddr;                   // apb byte address
  logic [31:0] pwdata;                  // apb write data
  logic [31:0] prdata;                  // apb read data
  logic        pready;                  // apb ready
  logic        pslverr;                 // apb error
  logic        effect_done;             // engine finished an effect
  logic        effect_start;            // play request pulse
  logic [6:0]  effect_index;            // effect to play
  logic        effect_abort;            // cancel pulse
  logic        seq_busy;                // sequence running
  int          error_cnt;               // mismatches
  int          checked;                 // comparisons made
  logic [31:0] rd;                      // last read data
  logic        er;                      // last error flag
  int          n;                       // cycle counter

  hws_sequencer #(.SLOT_COUNT(8), .UNIT_CYCLES(UNIT)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .effect_done(effect_done), .effect_start(effect_start), .effect_index(effect_index),
    .effect_abort(effect_abort), .seq_busy(seq_busy));

  // clock at 50 mhz
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("pready", 1, k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // wait for a play request, check its index, answer after a short effect
  task automatic play(input logic [6:0] exp);
    int k;
    k = 0;
    while (effect_start !== 1'b1 && k < 10) begin
      @(posedge pclk);
      k++;
    end
    chk("effect_start", 1, effect_start);
    chk("effect_index", exp, effect_index);
    repeat (2) @(posedge pclk);
    effect_done <= 1'b1;
    @(posedge pclk);
    effect_done <= 1'b0;
  endtask : play

  // count cycles until the sequence stops; flags any extra play request
  task automatic wait_idle(input int lim);
    n = 0;
    while (seq_busy !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
      if (effect_start === 1'b1) chk("extra start", 0, 1);
    end
    chk("seq_busy end", 0, seq_busy);
  endtask : wait_idle

  // reset values and register access kinds
  task automatic t_reset_regs();
    apb(0, SLOT_FIRST_IDX, 0);
    chk("slot first rst", 32'h01, rd);
    apb(0, SLOT_SECOND_IDX, 0);
    chk("slot second rst", 32'h00, rd);
    apb(0, CTRL_IDX, 0);
    chk("ctrl rst", 32'h00, rd);
    apb(1, SLOT_SECOND_IDX, 32'h0000_00a5);
    apb(0, SLOT_SECOND_IDX, 0);
    chk("slot second rw", 32'ha5, rd[7:0]);
    chk("slot rd err", 0, er);
    apb(1, 6'h3f, 32'h0000_00ff);
    chk("unmapped wr err", 1, er);
    apb(0, 6'h3f, 0);
    chk("unmapped rd err", 1, er);
    chk("unmapped rd data", 0, rd);
  endtask : t_reset_regs

  // effect, then a three unit delay, then a zero slot ends it
  task automatic t_effect_delay_stop();
    apb(1, SLOT_FIRST_IDX, 32'h05);
    apb(1, SLOT_SECOND_IDX, 32'h83);
    apb(1, SLOT_FIRST_IDX + 6'h2, 32'h00);
    apb(1, CTRL_IDX, 32'h1);
    play(7'h05);
    apb(0, CTRL_IDX, 0);
    chk("start bit held", 1, rd[GO_BIT]);
    wait_idle(60);
    // delay fetch to stop: three units plus two, seen from the read's end
    chk("delay long enough", 1, n >= 3 * UNIT);
    chk("delay not too long", 1, n <= 3 * UNIT + 2);
    apb(0, CTRL_IDX, 0);
    chk("start bit cleared", 0, rd[GO_BIT]);
    // stopped on the zero slot: pointer 2, state idle
    apb(0, STATUS_IDX, 0);
    chk("status stop slot", 32'h2, rd);
  endtask : t_effect_delay_stop

  // all eight slots nonzero: eight plays, then stop
  task automatic t_eight_slots();
    for (int k = 0; k < 8; k++) begin
      apb(1, SLOT_FIRST_IDX + 6'(k), 32'(k + 1));
    end
    apb(1, CTRL_IDX, 32'h1);
    for (int k = 0; k < 8; k++) begin
      play(7'(k + 1));
    end
    wait_idle(20);
  endtask : t_eight_slots

  // clearing the start bit mid effect cancels at once
  task automatic t_cancel();
    apb(1, SLOT_FIRST_IDX, 32'h07);
    apb(1, CTRL_IDX, 32'h1);
    n = 0;
    while (effect_start !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk("cancel start", 1, effect_start);
    apb(1, CTRL_IDX, 32'h0);
    chk("abort pulse", 1, effect_abort);
    chk("busy dropped", 0, seq_busy);
    wait_idle(10);
  endtask : t_cancel

  // verdict and end of run
  task automatic results();
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // watchdog against a hang
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  // main sequence
  initial begin
    error_cnt   = 0;
    checked     = 0;
    presetn     <= 1'b0;
    psel        <= 1'b0;
    penable     <= 1'b0;
    pwrite      <= 1'b0;
    paddr       <= 8'h00;
    pwdata      <= 32'h0;
    effect_done <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_regs();
    t_effect_delay_stop();
    t_eight_slots();
    t_cancel();
    results();
  end
endmodule : tb
